// file: logic/chan_regs_pkg.sv
// Constants and types shared by the channel reset and status register bank.
package chan_regs_pkg;

  // Management frame addressing.
  localparam logic [4:0] PORT_ADDR = 5'h00; // Arbitrary port address.
  localparam logic [4:0] DEV_ADDR = 5'h1e;
  localparam logic [1:0] START_CODE = 2'h0;
  localparam logic [1:0] OP_ADDRESS = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ_INC = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [4:0] HDR_LAST_BIT = 5'h0d;
  localparam logic [4:0] TA_DRIVE_BIT = 5'h0f;
  localparam logic [4:0] FRAME_LAST_BIT = 5'h1f;

  // Register addresses.
  localparam logic [15:0] CHANNEL_RESET_CONTROL_ADDR = 16'h000e;
  localparam logic [15:0] CHANNEL_STATUS_FIRST_ADDR = 16'h000f;
  localparam logic [15:0] LINE_ERROR_TALLY_ADDR = 16'h0010;

  // Reset values.
  localparam logic [7:0] RESET_CONTROL_RST = 8'h00;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] TALLY_RST = 16'hfffd;
  localparam logic [15:0] TALLY_MAX = 16'hffff;

  // Reset control field positions.
  localparam int DATAPATH_RESET_BIT = 3;
  localparam int TX_RESTART_BIT = 2;
  localparam int RX_RESTART_BIT = 1;

  // Status field positions.
  localparam int ST_PATTERN = 15;
  localparam int ST_ALIGNED = 14;
  localparam int ST_LOS = 13;
  localparam int ST_CAL = 12;
  localparam int ST_AGC = 11;
  localparam int ST_SYNC = 10;
  localparam int ST_RSVD9 = 9;
  localparam int ST_CODE = 8;
  localparam int ST_TX_UNDER = 7;
  localparam int ST_TX_OVER = 6;
  localparam int ST_RX_UNDER = 5;
  localparam int ST_RX_OVER = 4;
  localparam int ST_SYS_LINK = 3;
  localparam int ST_SLAVE_LINK = 2;
  localparam int ST_SYS_PLL = 1;
  localparam int ST_LINE_PLL = 0;

  // Latch kind per status bit: latched-high and latched-low masks; ST_PATTERN is in neither and reads live.
  localparam logic [15:0] LH_MASK = 16'h23f0;
  localparam logic [15:0] LL_MASK = 16'h5c0f;

  typedef enum logic [1:0] {
    MODE_KR = 2'b00,
    MODE_XAUI = 2'b01,
    MODE_KX = 2'b10
  } mode_t;

  typedef enum logic [0:0] {
    FR_PREAMBLE = 1'b0,
    FR_FRAME = 1'b1
  } frame_state_t;

  // Live indications from the channel datapath, all on clk_i.
  typedef struct packed {
    logic line_pattern_locked;
    logic system_lanes_aligned;
    logic line_signal_lost;
    logic line_calibration_finished;
    logic line_gain_loop_locked;
    logic line_sync_achieved;
    logic line_code_violation;
    logic tx_fifo_underflow;
    logic tx_fifo_overflow;
    logic rx_fifo_underflow;
    logic rx_fifo_overflow;
    logic rx_fifo_error;
    logic system_receive_link_up;
    logic alignment_slave_link_up;
    logic system_side_pll_locked;
    logic line_side_pll_locked;
  } channel_status_t;

endpackage

// file: logic/channel_reset_and_status_regs.sv
// Channel reset control and status registers behind a management serial port.
`timescale 1ns/1ns

module channel_reset_and_status_regs
  import chan_regs_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Management serial pins.
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  // Channel indications and mode.
  input wire channel_status_t status_i,
  input wire mode_t mode_i,
  input wire logic decoder_active_i,
  input wire logic jitter_check_i,
  input wire logic functional_mode_i,
  // Channel reset controls.
  output logic datapath_reset_o,
  output logic transmit_buffer_restart_o,
  output logic receive_buffer_restart_o
);

  logic mdc_s1_q, mdc_s2_q, mdc_s3_q;
  logic mdio_s1_q, mdio_s2_q;
  frame_state_t fstate_q;
  logic [5:0] pre_cnt_q;
  logic [4:0] bit_cnt_q;
  logic [12:0] hdr_q;
  logic [15:0] data_q;
  logic [15:0] addr_q;
  logic [1:0] op_q;
  logic hit_q;
  logic [15:0] rd_sh_q;
  logic [7:0] rst_ctl_q;
  logic [15:0] latch_q;
  logic [15:0] tally_q;
  logic mdio_q, mdio_oe_q;

  // The pins are asynchronous to clk_i, so both pass two flip-flops first.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mdc_s1_q <= 1'b0;
      mdc_s2_q <= 1'b0;
      mdc_s3_q <= 1'b0;
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
    end else begin
      mdc_s1_q <= mdc_i;
      mdc_s2_q <= mdc_s1_q;
      mdc_s3_q <= mdc_s2_q;
      mdio_s1_q <= mdio_i;
      mdio_s2_q <= mdio_s1_q;
    end
  end

  wire mdc_rise = mdc_s2_q & ~mdc_s3_q;
  wire mdc_fall = ~mdc_s2_q & mdc_s3_q;
  wire in_frame = (fstate_q == FR_FRAME);
  wire [13:0] hdr_next = {hdr_q, mdio_s2_q};
  wire [15:0] data_next = {data_q[14:0], mdio_s2_q};
  wire hdr_done = mdc_rise & in_frame & (bit_cnt_q == HDR_LAST_BIT);
  wire frame_end = mdc_rise & in_frame & (bit_cnt_q == FRAME_LAST_BIT);
  wire hdr_hit = (hdr_next[13:12] == START_CODE) &&
                 (hdr_next[9:5] == PORT_ADDR) && (hdr_next[4:0] == DEV_ADDR);
  wire [1:0] hdr_op = hdr_next[11:10];
  wire hdr_is_read = (hdr_op == OP_READ) || (hdr_op == OP_READ_INC);
  wire read_take = hdr_done & hdr_hit & hdr_is_read;
  wire wr_take = frame_end & hit_q & (op_q == OP_WRITE);
  wire addr_take = frame_end & hit_q & (op_q == OP_ADDRESS);
  wire wr_rst = wr_take & (addr_q == CHANNEL_RESET_CONTROL_ADDR);
  wire rd_status = read_take & (addr_q == CHANNEL_STATUS_FIRST_ADDR);
  wire rd_tally = read_take & (addr_q == LINE_ERROR_TALLY_ADDR);

  // Frame tracking: 32 ones of preamble, then 32 frame bits.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fstate_q <= FR_PREAMBLE;
      pre_cnt_q <= 6'h00;
      bit_cnt_q <= 5'h00;
      hdr_q <= 13'h0000;
      data_q <= 16'h0000;
    end else if (mdc_rise) begin
      case (fstate_q)
        FR_PREAMBLE: begin
          if (mdio_s2_q) begin
            if (pre_cnt_q != PREAMBLE_ONES) begin
              pre_cnt_q <= pre_cnt_q + 6'h01;
            end
          end else if (pre_cnt_q == PREAMBLE_ONES) begin
            fstate_q <= FR_FRAME;
            bit_cnt_q <= 5'h01;
            hdr_q <= 13'h0000;
          end else begin
            pre_cnt_q <= 6'h00;
          end
        end
        FR_FRAME: begin
          hdr_q <= hdr_next[12:0];
          data_q <= data_next;
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (bit_cnt_q == FRAME_LAST_BIT) begin
            fstate_q <= FR_PREAMBLE;
            pre_cnt_q <= 6'h00;
          end
        end
        default: begin
          fstate_q <= FR_PREAMBLE;
        end
      endcase
    end
  end

  // Operation capture and register address pointer.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op_q <= OP_ADDRESS;
      hit_q <= 1'b0;
      addr_q <= 16'h0000;
    end else begin
      if (hdr_done) begin
        op_q <= hdr_op;
        hit_q <= hdr_hit;
      end
      if (addr_take) begin
        addr_q <= data_next;
      end else if (read_take && hdr_op == OP_READ_INC) begin
        addr_q <= addr_q + 16'h0001;
      end
    end
  end

  // Reset control register; writes win over the self-clear.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_ctl_q <= RESET_CONTROL_RST;
    end else if (wr_rst) begin
      rst_ctl_q <= data_next[7:0];
    end else if (mdc_rise) begin
      rst_ctl_q[DATAPATH_RESET_BIT] <= 1'b0;
      rst_ctl_q[TX_RESTART_BIT] <= 1'b0;
      rst_ctl_q[RX_RESTART_BIT] <= 1'b0;
    end
  end

  // Registers are not in the reset's reach, so the host may pulse it
  // after configuring the mode without losing that configuration.
  assign datapath_reset_o = rst_ctl_q[DATAPATH_RESET_BIT];
  // KR buffers centre themselves, so the restarts act only in XAUI mode.
  assign transmit_buffer_restart_o =
    rst_ctl_q[TX_RESTART_BIT] & (mode_i == MODE_XAUI);
  assign receive_buffer_restart_o =
    rst_ctl_q[RX_RESTART_BIT] & (mode_i == MODE_XAUI);

  // Live status word with the mode qualifications applied.
  logic [15:0] live;
  wire is_kx = (mode_i == MODE_KX);
  always_comb begin
    live = 16'h0000;
    live[ST_PATTERN] = status_i.line_pattern_locked &
                       (mode_i != MODE_KR);
    live[ST_ALIGNED] = status_i.system_lanes_aligned;
    live[ST_LOS] = status_i.line_signal_lost;
    live[ST_CAL] = status_i.line_calibration_finished;
    live[ST_AGC] = status_i.line_gain_loop_locked;
    live[ST_SYNC] = status_i.line_sync_achieved;
    live[ST_CODE] = status_i.line_code_violation &
                    (decoder_active_i | jitter_check_i);
    live[ST_TX_UNDER] = status_i.tx_fifo_underflow & ~is_kx;
    live[ST_TX_OVER] = status_i.tx_fifo_overflow & ~is_kx;
    live[ST_RX_UNDER] = status_i.rx_fifo_underflow & ~is_kx;
    live[ST_RX_OVER] = is_kx ? status_i.rx_fifo_error :
                       status_i.rx_fifo_overflow;
    live[ST_SYS_LINK] = status_i.system_receive_link_up &
                        (mode_i == MODE_XAUI);
    live[ST_SLAVE_LINK] = status_i.alignment_slave_link_up;
    live[ST_SYS_PLL] = status_i.system_side_pll_locked;
    live[ST_LINE_PLL] = status_i.line_side_pll_locked;
  end

  // A read reloads the live state, but an event in the same cycle still
  // lands because the OR and AND terms are applied to the reloaded value.
  wire [15:0] latch_base = rd_status ? live : latch_q;
  wire [15:0] latch_next = (((latch_base | live) & LH_MASK) |
                            ((latch_base & live) & LL_MASK));
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      latch_q <= STATUS_RST;
    end else begin
      latch_q <= latch_next;
    end
  end

  // Error tally saturates rather than wraps; a clear loses no event.
  wire tally_evt = functional_mode_i & status_i.line_code_violation;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tally_q <= TALLY_RST;
    end else if (rd_tally) begin
      tally_q <= {15'h0000, tally_evt};
    end else if (tally_evt && tally_q != TALLY_MAX) begin
      tally_q <= tally_q + 16'h0001;
    end
  end

  // Read data selection; unmapped addresses read zero.
  wire [15:0] status_word = {live[ST_PATTERN], latch_q[14:10], 1'b0,
                             latch_q[8:0]};
  wire [15:0] rst_word = {8'h00, rst_ctl_q};
  wire [15:0] rd_mux =
    (addr_q == CHANNEL_RESET_CONTROL_ADDR) ? rst_word :
    (addr_q == CHANNEL_STATUS_FIRST_ADDR) ? status_word :
    (addr_q == LINE_ERROR_TALLY_ADDR) ? tally_q : 16'h0000;

  // Read data leaves on falling edges: turnaround zero, then 16 data bits.
  wire rd_frame = in_frame & hit_q & op_q[1];
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_sh_q <= 16'h0000;
      mdio_q <= 1'b1;
      mdio_oe_q <= 1'b0;
    end else if (read_take) begin
      rd_sh_q <= rd_mux;
    end else if (mdc_fall) begin
      if (rd_frame && bit_cnt_q == TA_DRIVE_BIT) begin
        mdio_q <= 1'b0;
        mdio_oe_q <= 1'b1;
      end else if (rd_frame && bit_cnt_q > TA_DRIVE_BIT) begin
        mdio_q <= rd_sh_q[15];
        rd_sh_q <= {rd_sh_q[14:0], 1'b0};
        mdio_oe_q <= 1'b1;
      end else begin
        mdio_q <= 1'b1;
        mdio_oe_q <= 1'b0;
      end
    end
  end

  assign mdio_o = mdio_q;
  assign mdio_oe_o = mdio_oe_q;

  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  dp_write_pulse_a: assert property (
    wr_rst && data_next[DATAPATH_RESET_BIT] |=> datapath_reset_o)
    else $error("datapath reset did not follow the write");

  self_clear_a: assert property (
    datapath_reset_o && mdc_rise && !wr_rst |=> !datapath_reset_o)
    else $error("datapath reset did not self-clear");

  tx_restart_mode_a: assert property (
    transmit_buffer_restart_o |-> mode_i == MODE_XAUI)
    else $error("transmit restart outside XAUI mode");

  rx_restart_mode_a: assert property (
    receive_buffer_restart_o |-> mode_i == MODE_XAUI)
    else $error("receive restart outside XAUI mode");

  los_sets_a: assert property (
    status_i.line_signal_lost |=> latch_q[ST_LOS])
    else $error("loss of signal not latched");

  los_holds_a: assert property (
    latch_q[ST_LOS] && !rd_status |=> latch_q[ST_LOS] [*1])
    else $error("latched-high bit dropped without a read");

  pll_low_holds_a: assert property (
    !latch_q[ST_LINE_PLL] && !rd_status |=> !latch_q[ST_LINE_PLL])
    else $error("latched-low bit rose without a read");

  reserved_zero_a: assert property (
    addr_q == CHANNEL_RESET_CONTROL_ADDR |-> rd_mux[15:8] == 8'h00)
    else $error("reset register high byte not zero");

  tally_step_a: assert property (
    tally_evt && !rd_tally && tally_q != TALLY_MAX
    |=> tally_q == $past(tally_q) + 16'h0001)
    else $error("error tally did not count");

  kx_fifo_error_a: assert property (
    is_kx && status_i.rx_fifo_error |=> latch_q[ST_RX_OVER])
    else $error("KX FIFO error not latched");

  code_latch_a: assert property (
    status_i.line_code_violation && (decoder_active_i || jitter_check_i)
    |=> latch_q[ST_CODE])
    else $error("code violation not latched");

  pattern_kr_a: assert property (
    mode_i == MODE_KR |-> !status_word[ST_PATTERN])
    else $error("pattern lock shown in KR mode");

  sync_low_a: assert property (
    !status_i.line_sync_achieved |=> !latch_q[ST_SYNC])
    else $error("sync loss not latched low");

  kx_underflow_a: assert property (
    is_kx && !latch_q[ST_TX_UNDER] |=> !latch_q[ST_TX_UNDER])
    else $error("transmit underflow latched in KX mode");

  sys_link_mode_a: assert property (
    mode_i != MODE_XAUI |=> !latch_q[ST_SYS_LINK])
    else $error("system link latched outside XAUI mode");

  pll_reload_a: assert property (
    rd_status |=>
    latch_q[ST_LINE_PLL] == $past(status_i.line_side_pll_locked))
    else $error("status read did not reload the line PLL bit");

  cov_status_read_c: cover property (rd_status ##[1:300] mdio_oe_o);
  cov_reset_write_c: cover property (wr_rst ##1 datapath_reset_o);
  cov_addr_frame_c: cover property (addr_take);
  cov_tally_clear_c: cover property (rd_tally);
  cov_xaui_restart_c: cover property (transmit_buffer_restart_o);

endmodule

// file: tb/mdio_host_model.sv
// Station management host model that sends frames on the management pins.
`timescale 1ns/1ns

module mdio_host_model
  import chan_regs_pkg::*;
(
  // Clock.
  input wire logic clk_i,
  // Management pins.
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic mdio_i,
  // Read results.
  output logic rd_done_o,
  output logic [15:0] rd_data_o
);
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
    rd_done_o = 1'b0;
    rd_data_o = 16'h0000;
  end

  // The line is sampled just before the rise, well after the device moved it.
  task automatic clock_bit(input logic drv, input logic val, output logic got);
    @(negedge clk_i);
    mdio_oe_o = drv;
    mdio_o = drv ? val : 1'b1;
    repeat (6) @(negedge clk_i);
    got = mdio_i;
    mdc_o = 1'b1;
    repeat (6) @(negedge clk_i);
    mdc_o = 1'b0;
  endtask

  // The clock stands still between frames, so each frame brings a preamble.
  task automatic frame(input logic [1:0] op, input logic [15:0] data,
                       output logic [15:0] got);
    logic [31:0] bits;
    logic b;
    bits = {START_CODE, op, PORT_ADDR, DEV_ADDR, 2'b10, data};
    got = 16'h0000;
    for (int i = 0; i < 32; i++) begin
      clock_bit(1'b1, 1'b1, b);
    end
    for (int i = 31; i >= 0; i--) begin
      clock_bit(!(op[1] && i < 18), bits[i], b);
      got = {got[14:0], b};
    end
  endtask

  task automatic write_reg(input logic [15:0] addr, input logic [15:0] data);
    logic [15:0] got;
    frame(OP_ADDRESS, addr, got);
    frame(OP_WRITE, data, got);
  endtask

  task automatic read_reg(input logic [15:0] addr);
    logic [15:0] got;
    frame(OP_ADDRESS, addr, got);
    frame(OP_READ, 16'h0000, got);
    @(negedge clk_i);
    rd_data_o = got;
    rd_done_o = 1'b1;
    @(negedge clk_i);
    rd_done_o = 1'b0;
  endtask
endmodule

// file: tb/test_channel_reset_and_status_regs.sv
// Self-checking bench for the channel reset and status register bank.
`timescale 1ns/1ns

module test_channel_reset_and_status_regs;
  import chan_regs_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  channel_status_t status_i = 16'h0000;
  channel_status_t s;
  mode_t mode_i = MODE_KR;
  logic decoder_active_i = 1'b0;
  logic jitter_check_i = 1'b0;
  logic functional_mode_i = 1'b0;
  logic mdc, host_o, host_oe, dev_o, dev_oe, mdio_wire, rd_done, clr, q;
  logic datapath_reset_o, transmit_buffer_restart_o, receive_buffer_restart_o;
  logic [2:0] seen = 3'b000;
  logic [15:0] rd_data, fs, ft;
  logic [31:0] note, r;
  logic [31:0] exp_q[$];
  int err_count = 0;
  int comparisons = 0;
  int seed = 32'h7e121f01;

  always #10 clk_i = ~clk_i;
  // The management data line has a pull-up when nobody drives it.
  assign mdio_wire = host_oe ? host_o : (dev_oe ? dev_o : 1'b1);

  mdio_host_model i_mdio_host_model (.clk_i(clk_i), .mdc_o(mdc),
    .mdio_o(host_o), .mdio_oe_o(host_oe), .mdio_i(mdio_wire),
    .rd_done_o(rd_done), .rd_data_o(rd_data));

  channel_reset_and_status_regs i_channel_reset_and_status_regs (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .mdc_i(mdc), .mdio_i(mdio_wire),
    .mdio_o(dev_o), .mdio_oe_o(dev_oe), .status_i(status_i), .mode_i(mode_i),
    .decoder_active_i(decoder_active_i), .jitter_check_i(jitter_check_i),
    .functional_mode_i(functional_mode_i),
    .datapath_reset_o(datapath_reset_o),
    .transmit_buffer_restart_o(transmit_buffer_restart_o),
    .receive_buffer_restart_o(receive_buffer_restart_o));

  always @(posedge clk_i) begin
    seen <= clr ? 3'b000 : seen | {datapath_reset_o,
      transmit_buffer_restart_o, receive_buffer_restart_o};
  end

  task automatic check(input string what, input logic [15:0] got,
                       input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  always @(posedge clk_i) begin
    if (rd_done === 1'b1) begin
      note = exp_q.pop_front();
      check("read data", rd_data & note[31:16], note[15:0]);
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] m,
                    input logic [15:0] e);
    exp_q.push_back({m, e});
    i_mdio_host_model.read_reg(a);
  endtask

  task automatic wait_dp();
    int n;
    n = 0;
    while (datapath_reset_o !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 20) begin
      err_count++;
      $display("BAD datapath reset expected 1 seen timeout");
      conclude();
    end
  endtask

  function automatic logic [15:0] f(channel_status_t v, mode_t m, logic g);
    logic kx;
    kx = (m == MODE_KX);
    return {v.line_pattern_locked & (m != MODE_KR),
      v.system_lanes_aligned, v.line_signal_lost,
      v.line_calibration_finished, v.line_gain_loop_locked,
      v.line_sync_achieved, 1'b0, v.line_code_violation & g,
      v.tx_fifo_underflow & !kx, v.tx_fifo_overflow & !kx,
      v.rx_fifo_underflow & !kx,
      kx ? v.rx_fifo_error : v.rx_fifo_overflow,
      v.system_receive_link_up & (m == MODE_XAUI),
      v.alignment_slave_link_up, v.system_side_pll_locked,
      v.line_side_pll_locked};
  endfunction

  initial begin
    clr = 1'b0;
    repeat (6) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    check("data enable", dev_oe, 1'b0);
    check("datapath reset", datapath_reset_o, 1'b0);
    rd(CHANNEL_STATUS_FIRST_ADDR, 16'hffff, STATUS_RST);
    rd(LINE_ERROR_TALLY_ADDR, 16'hffff, TALLY_RST);
    rd(16'h0020, 16'hffff, 16'h0000);
    $display("reset test done");
    for (int j = 0; j < 3; j++) begin
      mode_i = mode_t'(j);
      clr = 1'b1;
      @(negedge clk_i);
      clr = 1'b0;
      // The channel is restarted only once its mode is set.
      i_mdio_host_model.write_reg(CHANNEL_RESET_CONTROL_ADDR,
        16'hffff);
      wait_dp();
      check("datapath reset", datapath_reset_o, 1'b1);
      rd(CHANNEL_RESET_CONTROL_ADDR, 16'hffff, 16'h00f1);
      check("datapath reset cleared", datapath_reset_o, 1'b0);
      check("tx restart", seen[1], j == 1);
      check("rx restart", seen[0], j == 1);
      $display("reset control test done in mode %0d", j);
    end
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      mode_i = mode_t'(k % 3);
      s = r[15:0];
      status_i = s;
      decoder_active_i = r[16];
      jitter_check_i = r[17];
      q = r[16] | r[17];
      fs = f(s, mode_i, q);
      ft = f((s | LH_MASK) & ~LL_MASK, mode_i, q);
      rd(CHANNEL_STATUS_FIRST_ADDR, 16'h0000, 16'h0000);
      rd(CHANNEL_STATUS_FIRST_ADDR, 16'hffff, fs);
      status_i = (s | LH_MASK) & ~LL_MASK;
      @(negedge clk_i);
      status_i = s;
      rd(CHANNEL_STATUS_FIRST_ADDR, 16'hffff, ((fs | ft) & LH_MASK) |
        (fs & ft & LL_MASK) | (fs & 16'h8000));
      rd(CHANNEL_STATUS_FIRST_ADDR, 16'hffff, fs);
      $display("status latch test done in round %0d", k);
    end
    for (int fm = 0; fm < 2; fm++) begin
      status_i = 16'h0000;
      functional_mode_i = fm[0];
      rd(LINE_ERROR_TALLY_ADDR, 16'h0000, 16'h0000);
      status_i.line_code_violation = 1'b1;
      repeat (5) @(negedge clk_i);
      status_i.line_code_violation = 1'b0;
      rd(LINE_ERROR_TALLY_ADDR, 16'hffff, fm ? 16'h0005 : 16'h0000);
      $display("tally test done with functional mode %0d", fm);
    end
    conclude();
  end
endmodule
